// ---- dv/ssm_ctrl_model.sv ----
// fieldbus controller stand-in: sends output telegrams, collects input telegrams.
// assumes the block's telegram ports run on hclk with an active-low async reset.
`timescale 1ns/100ps
module ssm_ctrl_model (
    input wire logic hclk,
    input wire logic hresetn,
    output ssm_pkg::ssm_out_tlg_t tlg_out,
    output logic tlg_out_valid,
    input wire ssm_pkg::ssm_in_tlg_t tlg_in,
    input wire logic tlg_in_valid
);
    import ssm_pkg::*;

    ssm_in_tlg_t rx_q[$];

    initial begin
        tlg_out = '0;
        tlg_out_valid = 1'b0;
    end

    // ==========================================================
    // collection
    // every input telegram is queued for the bench to compare
    always @(posedge hclk) begin
        if (hresetn && tlg_in_valid === 1'b1) begin
            rx_q.push_back(tlg_in);
        end
    end

    // ==========================================================
    // sending
    // selection and restarts reach the scanner only through this telegram
    task automatic send(input logic [7:0] b0, input logic [7:0] b2, input logic [7:0] b4,
                        input logic [7:0] st, input logic [23:0] crc, input logic [1:0] mode,
                        input logic noise, input int gap);
        ssm_out_tlg_t t;
        t = '0;
        t.mode_bytes[0] = noise ? b0 : {3'h0, b0[4:0]};
        t.mode_bytes[2] = noise ? b2 : {3'h0, b2[4:0]};
        if (!noise && mode == 2'd0) begin
            t.mode_bytes[2] = 8'h00;
        end
        t.mode_bytes[4] = noise ? b4 : {6'h0, b4[1:0]};
        // noise only when a scenario asks, to prove reserved places are ignored
        if (noise) begin
            t.mode_bytes[1] = ~b0;
            t.mode_bytes[3] = ~b2;
            t.mode_bytes[5] = ~b4;
            t.rsv_b6 = 8'h5a;
        end
        t.status = st;
        {t.crc_byte_high, t.crc_byte_mid, t.crc_byte_low} = crc;
        @(posedge hclk);
        tlg_out <= t;
        tlg_out_valid <= 1'b1;
        @(posedge hclk);
        tlg_out_valid <= 1'b0;
        tlg_out <= ~t;  // stale data must not pass for a fresh telegram
        repeat (gap) @(posedge hclk);
    endtask
endmodule  // ssm_ctrl_model

// ---- dv/test_safe_signal_telegram_map.sv ----
// self-checking bench: register bus, input telegram build, output telegram decode, irq.
// assumes ssm_pkg, the block and ssm_ctrl_model are compiled before it.
`timescale 1ns/100ps
module test_safe_signal_telegram_map;
    import ssm_pkg::*;

    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic wf_a, pf_a, wf_b, pf_b, tlg_out_valid, tlg_in_valid, rst_wf, rst_pf, irq;
    ssm_out_tlg_t tlg_out;
    ssm_in_tlg_t tlg_in;
    logic [4:0] grp1, grp2;
    int failures = 0;
    int checks_done = 0;
    int seed = 32'h0dda374f;

    // ==========================================================
    // clock and instances
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    ssm_telegram_map uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .warn_field_free_a(wf_a),
        .prot_field_free_a(pf_a), .warn_field_free_b(wf_b), .prot_field_free_b(pf_b),
        .tlg_out(tlg_out), .tlg_out_valid(tlg_out_valid), .tlg_in(tlg_in),
        .tlg_in_valid(tlg_in_valid), .field_sel_grp1(grp1), .field_sel_grp2(grp2),
        .restart_wf_a(rst_wf), .restart_pf_a(rst_pf), .irq(irq));

    ssm_ctrl_model ctl (.hclk(hclk), .hresetn(hresetn), .tlg_out(tlg_out),
        .tlg_out_valid(tlg_out_valid), .tlg_in(tlg_in), .tlg_in_valid(tlg_in_valid));

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // address phase held until hready, then data phase held until hready
    task automatic ahb_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d,
                            output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wr ? d : 32'h0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0, "okay response");
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog, far beyond the thousand or so cycles the tests need
    initial begin
        #(40000 * 4);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end

    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] rd;
        logic [7:0] b0, b2, b4, st;
        logic [23:0] crc;
        logic [4:0] m_g1, m_g2, mask, stat;
        logic [1:0] mode;
        logic m_wf, m_pf, nz, auto, sel_ev, rst_ev;
        ssm_in_tlg_t t;
        {hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
        {wf_a, pf_a, wf_b, pf_b} = 4'h0;
        hresetn = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        hsize <= 3'b010;
        // reset state, identity, refused accesses
        chk({19'h0, irq, rst_pf, rst_wf, grp2, grp1}, 32'h0, "reset outputs");
        ahb_xfer(SSM_OFS_IRQ_MASK, 1'b0, 32'h0, rd);
        chk(rd, 32'h0, "mask reset");
        ahb_xfer(SSM_OFS_IDENT, 1'b0, 32'h0, rd);
        chk(rd, SSM_IDENT_VALUE, "ident");
        ahb_xfer(SSM_OFS_SEL, 1'b1, 32'hffffffff, rd);
        ahb_xfer(8'h40, 1'b1, 32'hffffffff, rd);
        ahb_xfer(8'h40, 1'b0, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
        ahb_xfer(SSM_OFS_SEL, 1'b0, 32'h0, rd);
        chk(rd, 32'h0, "read-only selection");
        $display("test reset done");
        // every combination of the four field states in an input telegram
        for (int i = 0; i < 16; i++) begin
            st = $random(seed);
            crc = $random(seed);
            ahb_xfer(SSM_OFS_TX_STATUS, 1'b1, {24'h0, st}, rd);
            ahb_xfer(SSM_OFS_TX_CRC, 1'b1, {8'h0, crc}, rd);
            {pf_b, wf_b, pf_a, wf_a} <= i[3:0];
            ahb_xfer(SSM_OFS_CTRL, 1'b1, 32'h8, rd);
            repeat (3) @(posedge hclk);
            chk(32'(ctl.rx_q.size()), 32'h1, "input telegram count");
            t = ctl.rx_q.pop_front();
            chk({8'h0, t.rsv_b2, t.func_b, t.func_a}, {16'h0, 6'h0, i[3:2], 6'h0, i[1:0]},
                "field bytes");
            chk({t.crc_byte_low, t.crc_byte_mid, t.crc_byte_high, t.status},
                {crc[7:0], crc[15:8], crc[23:16], st}, "status and crc");
            ahb_xfer(SSM_OFS_FIELDS, 1'b0, 32'h0, rd);
            chk(rd, {28'h0, i[3:0]}, "live field states");
        end
        $display("test input telegram done");
        // output telegrams in all four modes, with reserved noise and irq masking
        {m_g1, m_g2, m_wf, m_pf} = '0;
        for (int i = 0; i < 24; i++) begin
            mode = i[1:0];
            auto = (i >= 12);
            nz = $random(seed);
            {b0, b2, b4, st} = $random(seed);
            crc = $random(seed);
            mask = $random(seed);
            ahb_xfer(SSM_OFS_CTRL, 1'b1, {29'h0, auto, mode}, rd);
            ahb_xfer(SSM_OFS_IRQ_MASK, 1'b1, {27'h0, mask}, rd);
            ahb_xfer(SSM_OFS_IRQ_STAT, 1'b1, 32'h1f, rd);
            @(posedge hclk);
            chk({31'h0, irq}, 32'h0, "irq after clear");
            ctl.send(b0, b2, b4, st, crc, mode, nz, i % 3);
            // bench model of the decode; unsupported modes leave levels alone
            {sel_ev, rst_ev} = 2'b00;
            if (mode < 2'd2) begin
                sel_ev = {b0[4:0], (mode == 2'd1) ? b2[4:0] : 5'h0} != {m_g1, m_g2};
                rst_ev = (b4[0] & ~m_wf) | (b4[1] & ~m_pf);
                m_g1 = b0[4:0];
                m_g2 = (mode == 2'd1) ? b2[4:0] : 5'h0;
                {m_pf, m_wf} = b4[1:0];
            end
            stat = {mode >= 2'd2, rst_ev, sel_ev, auto, 1'b1};
            repeat (2) @(posedge hclk);
            chk({22'h0, grp2, grp1}, {22'h0, m_g2, m_g1}, "field selection");
            chk({30'h0, rst_pf, rst_wf}, {30'h0, m_pf, m_wf}, "restarts");
            ahb_xfer(SSM_OFS_SEL, 1'b0, 32'h0, rd);
            chk(rd, {13'h0, mode < 2'd2, m_pf, m_wf, 3'h0, m_g2, 3'h0, m_g1}, "sel reg");
            ahb_xfer(SSM_OFS_RX_STATUS, 1'b0, 32'h0, rd);
            chk(rd, {24'h0, st}, "rx status");
            ahb_xfer(SSM_OFS_RX_CRC, 1'b0, 32'h0, rd);
            chk(rd, {8'h0, crc}, "rx crc");
            ahb_xfer(SSM_OFS_IRQ_STAT, 1'b0, 32'h0, rd);
            chk(rd, {27'h0, stat}, "irq status");
            chk({31'h0, irq}, {31'h0, |(stat & mask)}, "irq level");
            if (auto) begin
                chk(32'(ctl.rx_q.size()), 32'h1, "auto reply count");
                t = ctl.rx_q.pop_front();
                chk({16'h0, t.func_b, t.func_a}, 32'h0303, "auto reply fields");
            end
            ctl.rx_q.delete();
        end
        $display("test output telegram done");
        summarize();
    end
endmodule  // test_safe_signal_telegram_map

// ---- logic/ssm_out_decode.sv ----
// Mode-dependent decoder of the output telegram.
// Pure combinational; the caller registers the result.
`timescale 1ns/100ps
module ssm_out_decode (
    input wire ssm_pkg::ssm_out_tlg_t tlg,
    input wire ssm_pkg::ssm_mode_t mode,
    output ssm_pkg::ssm_sel_t sel
);
    import ssm_pkg::*;

    // ==========================================================
    // mode decode
    wire is_5_10 = (mode == SSM_MODE_PAIRS_5_10);
    wire is_100 = (mode == SSM_MODE_PAIRS_100);
    // only low five bits are taken; bits 5..7, bytes 1, 3, 5, 6 ignored
    wire [SSM_FSEL_W-1:0] b0_sel = tlg.mode_bytes[0][SSM_FSEL_W-1:0]; // RULE_07
    wire [SSM_FSEL_W-1:0] b2_sel = tlg.mode_bytes[2][SSM_FSEL_W-1:0];

    // group 2 exists only with 100 field pairs
    assign sel.grp1 = b0_sel; // RULE_08
    assign sel.grp2 = is_100 ? b2_sel : 5'h00; // RULE_11
    assign sel.rst_wf_a = tlg.mode_bytes[4][0]; // RULE_09
    assign sel.rst_pf_a = tlg.mode_bytes[4][1]; // RULE_09
    // two-function and multi-config layouts are not handled here
    assign sel.mode_ok = is_5_10 | is_100; // RULE_10

endmodule // ssm_out_decode

// ---- logic/ssm_pkg.sv ----
// Shared constants and carriers for the safe signal telegram block.
// Assumes a 32-bit AHB-Lite register bus and a fieldbus side on the same clock.
package ssm_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] SSM_OFS_CTRL = 8'h00;
    localparam logic [7:0] SSM_OFS_TX_STATUS = 8'h04;
    localparam logic [7:0] SSM_OFS_TX_CRC = 8'h08;
    localparam logic [7:0] SSM_OFS_RX_STATUS = 8'h0c;
    localparam logic [7:0] SSM_OFS_RX_CRC = 8'h10;
    localparam logic [7:0] SSM_OFS_SEL = 8'h14;
    localparam logic [7:0] SSM_OFS_FIELDS = 8'h18;
    localparam logic [7:0] SSM_OFS_IRQ_STAT = 8'h1c;
    localparam logic [7:0] SSM_OFS_IRQ_MASK = 8'h20;
    localparam logic [7:0] SSM_OFS_IDENT = 8'h24;

    // ==========================================================
    // field positions
    localparam int SSM_CTRL_MODE_LSB = 0;
    localparam int SSM_CTRL_AUTO_BIT = 2;
    localparam int SSM_CTRL_SEND_BIT = 3;
    localparam int SSM_SEL_GRP2_LSB = 8;
    localparam int SSM_SEL_RST_WF_BIT = 16;
    localparam int SSM_SEL_RST_PF_BIT = 17;
    localparam int SSM_SEL_MODE_OK_BIT = 18;
    localparam int SSM_FSEL_W = 5;

    // interrupt event bits
    localparam int SSM_EV_RX = 0;
    localparam int SSM_EV_TX = 1;
    localparam int SSM_EV_SEL = 2;
    localparam int SSM_EV_RESTART = 3;
    localparam int SSM_EV_BAD_MODE = 4;
    localparam int SSM_EV_N = 5;

    // ==========================================================
    // reset values
    localparam logic [7:0] SSM_RST_TX_STATUS = 8'h00;
    localparam logic [23:0] SSM_RST_TX_CRC = 24'h000000;
    localparam logic [SSM_EV_N-1:0] SSM_RST_IRQ_MASK = 5'h00;
    // identity word, value is arbitrary
    localparam logic [31:0] SSM_IDENT_VALUE = 32'h5353_0001;

    // ==========================================================
    // function modes and bus states
    typedef enum logic [1:0] {
        SSM_MODE_PAIRS_5_10 = 2'b00,
        SSM_MODE_PAIRS_100 = 2'b01,
        SSM_MODE_MULTI_CFG = 2'b10,
        SSM_MODE_TWO_FUNC = 2'b11
    } ssm_mode_t;

    typedef enum logic [0:0] {
        SSM_BUS_IDLE = 1'b0,
        SSM_BUS_RD = 1'b1
    } ssm_bus_st_t;

    // ==========================================================
    // telegrams, byte 0 in the low bits
    typedef struct packed {
        logic [7:0] crc_byte_low;
        logic [7:0] crc_byte_mid;
        logic [7:0] crc_byte_high;
        logic [7:0] status;
        logic [7:0] rsv_b2;
        logic [7:0] func_b;
        logic [7:0] func_a;
    } ssm_in_tlg_t;

    typedef struct packed {
        logic [7:0] crc_byte_low;
        logic [7:0] crc_byte_mid;
        logic [7:0] crc_byte_high;
        logic [7:0] status;
        logic [7:0] rsv_b6;
        logic [5:0][7:0] mode_bytes;
    } ssm_out_tlg_t;

    typedef struct packed {
        logic [SSM_FSEL_W-1:0] grp1;
        logic [SSM_FSEL_W-1:0] grp2;
        logic rst_wf_a;
        logic rst_pf_a;
        logic mode_ok;
    } ssm_sel_t;

endpackage

// ---- logic/ssm_telegram_map.sv ----
// Safe signal telegram map: builds the input telegram, decodes the
// output telegram, AHB-Lite register slave and interrupt.
// Assumes the fieldbus side and the scanner core run on hclk.
//
// Functional notes
// RULE_01: byte 0 bit 0 is warning field A free
// RULE_02: byte 0 bit 1 is protective field A free
// RULE_03: byte 1 bit 0 is warning field B free
// RULE_04: byte 1 bit 1 is protective field B free
// RULE_05: field selection comes only from output telegram
// RULE_06: restart released only by telegram start bits
// RULE_07: bytes 0-5 per mode, byte 6 reserved
// RULE_08: 5/10 mode: byte 0 selects F1-F5
// RULE_09: byte 4 bits 0/1 request restarts
// RULE_10: 100 mode: byte 0 selects group 1
// RULE_11: 100 mode: byte 2 selects group 2
// RULE_12: status then CRC high, mid, low end telegram
// RULE_13: reserved sent as zero, ignored on receive
`timescale 1ns/100ps
module ssm_telegram_map (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic warn_field_free_a,
    input wire logic prot_field_free_a,
    input wire logic warn_field_free_b,
    input wire logic prot_field_free_b,
    input wire ssm_pkg::ssm_out_tlg_t tlg_out,
    input wire logic tlg_out_valid,
    output ssm_pkg::ssm_in_tlg_t tlg_in,
    output logic tlg_in_valid,
    output logic [ssm_pkg::SSM_FSEL_W-1:0] field_sel_grp1,
    output logic [ssm_pkg::SSM_FSEL_W-1:0] field_sel_grp2,
    output logic restart_wf_a,
    output logic restart_pf_a,
    output logic irq
);
    import ssm_pkg::*;

    // ==========================================================
    // register hit decode, shared by read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    // ==========================================================
    // state
    ssm_bus_st_t bus_st_r;
    ssm_bus_st_t bus_st_nxt;
    logic [7:0] ph_addr_r;
    logic ph_write_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;
    logic [1:0] mode_r;
    logic auto_r;
    logic [7:0] tx_status_r;
    logic [23:0] tx_crc_r;
    logic [7:0] rx_status_r;
    logic [23:0] rx_crc_r;
    logic [SSM_EV_N-1:0] irq_stat_r;
    logic [SSM_EV_N-1:0] irq_stat_nxt;
    logic [SSM_EV_N-1:0] irq_mask_r;
    logic irq_r;
    ssm_in_tlg_t tlg_in_r;
    ssm_in_tlg_t tlg_in_nxt;
    logic tlg_in_valid_r;
    logic [SSM_FSEL_W-1:0] grp1_r;
    logic [SSM_FSEL_W-1:0] grp2_r;
    logic rst_wf_r;
    logic rst_pf_r;
    logic mode_ok_r;
    ssm_sel_t dec;

    // ==========================================================
    // bus address phase and write strobes
    wire addr_ok = hsel & htrans[1] & hready;
    wire rd_start = addr_ok & ~hwrite;
    wire wr_en = ph_write_r;
    wire wr_ctrl = wr_en & hit(ph_addr_r, SSM_OFS_CTRL);
    wire wr_tx_st = wr_en & hit(ph_addr_r, SSM_OFS_TX_STATUS);
    wire wr_tx_crc = wr_en & hit(ph_addr_r, SSM_OFS_TX_CRC);
    wire wr_irq_st = wr_en & hit(ph_addr_r, SSM_OFS_IRQ_STAT);
    wire wr_irq_mk = wr_en & hit(ph_addr_r, SSM_OFS_IRQ_MASK);

    // ==========================================================
    // read mux, unmapped offsets read zero
    wire [31:0] sel_word = {13'h0000, mode_ok_r, rst_pf_r, rst_wf_r,
                            3'h0, grp2_r, 3'h0, grp1_r};
    wire [31:0] rd_mux =
        hit(ph_addr_r, SSM_OFS_CTRL) ? {29'h00000000, auto_r, mode_r} :
        hit(ph_addr_r, SSM_OFS_TX_STATUS) ? {24'h000000, tx_status_r} :
        hit(ph_addr_r, SSM_OFS_TX_CRC) ? {8'h00, tx_crc_r} :
        hit(ph_addr_r, SSM_OFS_RX_STATUS) ? {24'h000000, rx_status_r} :
        hit(ph_addr_r, SSM_OFS_RX_CRC) ? {8'h00, rx_crc_r} :
        hit(ph_addr_r, SSM_OFS_SEL) ? sel_word :
        hit(ph_addr_r, SSM_OFS_FIELDS) ? {28'h0000000, prot_field_free_b,
            warn_field_free_b, prot_field_free_a, warn_field_free_a} :
        hit(ph_addr_r, SSM_OFS_IRQ_STAT) ? {27'h0000000, irq_stat_r} :
        hit(ph_addr_r, SSM_OFS_IRQ_MASK) ? {27'h0000000, irq_mask_r} :
        hit(ph_addr_r, SSM_OFS_IDENT) ? SSM_IDENT_VALUE :
        32'h00000000;

    // reads take one wait state so hrdata can come from a flop
    always_comb begin
        bus_st_nxt = bus_st_r;
        case (bus_st_r)
            SSM_BUS_IDLE: begin
                if (rd_start) begin
                    bus_st_nxt = SSM_BUS_RD;
                end
            end
            SSM_BUS_RD: begin
                bus_st_nxt = SSM_BUS_IDLE;
            end
            default: begin
                bus_st_nxt = SSM_BUS_IDLE;
            end
        endcase
    end

    // bus phase registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_st_r <= SSM_BUS_IDLE;
            ph_addr_r <= 8'h00;
            ph_write_r <= 1'b0;
            hreadyout_r <= 1'b1;
            hrdata_r <= 32'h00000000;
            hresp_r <= 1'b0;
        end else begin
            bus_st_r <= bus_st_nxt;
            ph_write_r <= addr_ok & hwrite;
            hreadyout_r <= ~rd_start;
            hresp_r <= 1'b0; // always OKAY
            if (addr_ok) begin
                ph_addr_r <= haddr[7:0];
            end
            if (bus_st_r == SSM_BUS_RD) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    // ==========================================================
    // software control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= SSM_MODE_PAIRS_5_10;
            auto_r <= 1'b0;
            tx_status_r <= SSM_RST_TX_STATUS;
            tx_crc_r <= SSM_RST_TX_CRC;
            irq_mask_r <= SSM_RST_IRQ_MASK;
        end else begin
            if (wr_ctrl) begin
                mode_r <= hwdata[SSM_CTRL_MODE_LSB +: 2];
                auto_r <= hwdata[SSM_CTRL_AUTO_BIT];
            end
            if (wr_tx_st) begin
                tx_status_r <= hwdata[7:0];
            end
            if (wr_tx_crc) begin
                tx_crc_r <= hwdata[23:0];
            end
            if (wr_irq_mk) begin
                irq_mask_r <= hwdata[SSM_EV_N-1:0];
            end
        end
    end

    // ==========================================================
    // input telegram assembly
    wire send_now = (wr_ctrl & hwdata[SSM_CTRL_SEND_BIT]) | (auto_r & tlg_out_valid);

    // reserved bits are built as zero, never copied from anywhere
    always_comb begin
        tlg_in_nxt = '0; // RULE_13
        tlg_in_nxt.func_a[0] = warn_field_free_a; // RULE_01
        tlg_in_nxt.func_a[1] = prot_field_free_a; // RULE_02
        tlg_in_nxt.func_b[0] = warn_field_free_b; // RULE_03
        tlg_in_nxt.func_b[1] = prot_field_free_b; // RULE_04
        tlg_in_nxt.status = tx_status_r; // RULE_12
        tlg_in_nxt.crc_byte_high = tx_crc_r[23:16]; // RULE_12
        tlg_in_nxt.crc_byte_mid = tx_crc_r[15:8];
        tlg_in_nxt.crc_byte_low = tx_crc_r[7:0];
    end

    // telegram is frozen between sends so the CRC stays consistent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tlg_in_r <= '0;
            tlg_in_valid_r <= 1'b0;
        end else begin
            tlg_in_valid_r <= send_now;
            if (send_now) begin
                tlg_in_r <= tlg_in_nxt;
            end
        end
    end

    // ==========================================================
    // output telegram decode
    ssm_out_decode u_dec (
        .tlg(tlg_out),
        .mode(ssm_mode_t'(mode_r)),
        .sel(dec)
    );

    // selection only moves on a received telegram in a known mode
    wire take = tlg_out_valid & dec.mode_ok; // RULE_05
    wire sel_change = take & ((dec.grp1 != grp1_r) | (dec.grp2 != grp2_r));
    wire rst_rise = take & ((dec.rst_wf_a & ~rst_wf_r) | (dec.rst_pf_a & ~rst_pf_r));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            grp1_r <= 5'h00;
            grp2_r <= 5'h00;
            rst_wf_r <= 1'b0;
            rst_pf_r <= 1'b0;
            mode_ok_r <= 1'b0;
            rx_status_r <= 8'h00;
            rx_crc_r <= 24'h000000;
        end else begin
            if (tlg_out_valid) begin
                mode_ok_r <= dec.mode_ok;
                rx_status_r <= tlg_out.status; // RULE_12
                rx_crc_r <= {tlg_out.crc_byte_high, tlg_out.crc_byte_mid,
                             tlg_out.crc_byte_low};
            end
            if (take) begin
                grp1_r <= dec.grp1; // RULE_05
                grp2_r <= dec.grp2;
                rst_wf_r <= dec.rst_wf_a; // RULE_06
                rst_pf_r <= dec.rst_pf_a; // RULE_06
            end
        end
    end

    // ==========================================================
    // interrupt: sticky events, set wins over write-one-clear
    wire [SSM_EV_N-1:0] ev = {tlg_out_valid & ~dec.mode_ok, rst_rise, sel_change,
                              send_now, tlg_out_valid};
    wire [SSM_EV_N-1:0] clr = wr_irq_st ? hwdata[SSM_EV_N-1:0] : 5'h00;

    always_comb begin
        irq_stat_nxt = (irq_stat_r & ~clr) | ev;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= 5'h00;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_r <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    // ==========================================================
    // outputs
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign tlg_in = tlg_in_r;
    assign tlg_in_valid = tlg_in_valid_r;
    assign field_sel_grp1 = grp1_r;
    assign field_sel_grp2 = grp2_r;
    assign restart_wf_a = rst_wf_r;
    assign restart_pf_a = rst_pf_r;
    assign irq = irq_r;

    // ==========================================================
    // assertions
    a_wf_free_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
        tlg_in_valid |-> tlg_in.func_a[0] == $past(warn_field_free_a))
        else $error("warning field A bit wrong");
    a_pf_free_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
        tlg_in_valid |-> tlg_in.func_a[1] == $past(prot_field_free_a))
        else $error("protective field A bit wrong");
    a_wf_free_b: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
        tlg_in_valid |-> tlg_in.func_b[0] == $past(warn_field_free_b))
        else $error("warning field B bit wrong");
    a_pf_free_b: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
        tlg_in_valid |-> tlg_in.func_b[1] == $past(prot_field_free_b))
        else $error("protective field B bit wrong");
    a_sel_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
        !tlg_out_valid |=> $stable(field_sel_grp1) && $stable(field_sel_grp2))
        else $error("selection moved without telegram");
    a_restart_src: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
        $rose(restart_wf_a) |-> $past(tlg_out_valid) && $past(tlg_out.mode_bytes[4][0]))
        else $error("restart released without request bit");
    a_bad_mode: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
        tlg_out_valid && mode_r[1] |=> $stable(field_sel_grp1) && irq_stat_r[SSM_EV_BAD_MODE])
        else $error("unknown mode telegram not ignored");
    a_grp1_5_10: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_08
        tlg_out_valid && mode_r == SSM_MODE_PAIRS_5_10 |=>
        field_sel_grp1 == $past(tlg_out.mode_bytes[0][4:0]) && field_sel_grp2 == 5'h00)
        else $error("5/10 selection wrong");
    a_restart_pf: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
        tlg_out_valid && !mode_r[1] |=> restart_pf_a == $past(tlg_out.mode_bytes[4][1]))
        else $error("protective restart bit wrong");
    a_grp1_100: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
        tlg_out_valid && mode_r == SSM_MODE_PAIRS_100 |=>
        field_sel_grp1 == $past(tlg_out.mode_bytes[0][4:0]))
        else $error("group 1 selection wrong");
    a_grp2_100: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
        tlg_out_valid && mode_r == SSM_MODE_PAIRS_100 |=>
        field_sel_grp2 == $past(tlg_out.mode_bytes[2][4:0]))
        else $error("group 2 selection wrong");
    a_crc_order: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        tlg_in_valid |-> {tlg_in.status, tlg_in.crc_byte_high, tlg_in.crc_byte_mid,
        tlg_in.crc_byte_low} == $past({tx_status_r, tx_crc_r}))
        else $error("status or crc bytes misplaced");
    a_rsv_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_13
        tlg_in_valid |-> tlg_in.func_a[7:2] == 6'h00 && tlg_in.func_b[7:2] == 6'h00
        && tlg_in.rsv_b2 == 8'h00)
        else $error("reserved bits not zero");

    // bus timing, sticky events and send strobe; reads cost one wait state
    a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_start |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_ok && hwrite |=> hreadyout && !hresp)
        else $error("write not zero wait or not okay");
    a_event_set: assert property (@(posedge hclk) disable iff (!hresetn)
        (|ev) |=> (irq_stat_r & $past(ev)) == $past(ev))
        else $error("event lost against clear");
    a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
        irq == |(irq_stat_r & $past(irq_mask_r)))
        else $error("irq level wrong");
    a_send_pulse: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        tlg_in_valid == $past(send_now))
        else $error("send strobe wrong");

endmodule // ssm_telegram_map
